// >>> sim/gain_ctrl_model.sv
// gain-ranging controller model that inserts an attenuator while the indicator is high
`timescale 1ns/1ps
`default_nettype none
module gain_ctrl_model (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic near_full_scale_flag,
	output var logic  atten_on,
	output var int    inserts
);
	// relay driver follows the indicator one clock late; counts insertions so the bench sees each event once
	always_ff @(posedge clk) begin
		if (reset) begin
			atten_on <= 1'b0;
			inserts  <= 0;
		end else begin
			atten_on <= near_full_scale_flag;
			if (near_full_scale_flag && !atten_on)
				inserts <= inserts + 1;
		end
	end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the fast threshold detector
`timescale 1ns/1ps
`default_nettype none
`include "fast_detect_defs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
	logic                     clk;
	logic                     reset;
	fast_detect_pkg::sample_t sample;
	logic                     overrange_in;
	logic                     reg_wr;
	logic                     reg_rd;
	logic [7:0]               reg_addr;
	logic [7:0]               reg_wdata;
	logic [7:0]               reg_rdata;
	logic                     near_full_scale_flag;
	logic                     overrange_flag;
	logic                     atten_on;
	int                       inserts;
	int                       num_errors;
	int                       checks;
	int                       cycles;
	logic [7:0]               regs_a [7] = '{`FD_ADDR_CONTROL, `FD_ADDR_UPPER_LO, `FD_ADDR_UPPER_HI,
		`FD_ADDR_LOWER_LO, `FD_ADDR_LOWER_HI, `FD_ADDR_DWELL_LO, `FD_ADDR_DWELL_HI};
	logic [7:0]               rst_v [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
	logic [7:0]               new_v [7] = '{8'h01, 8'hFF, 8'h0F, 8'h1D, 8'h0A, 8'h14, 8'h00};

	fast_threshold_detect fast_threshold_detect_inst (
		.clk(clk), .reset(reset), .sample(sample), .overrange_in(overrange_in),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .near_full_scale_flag(near_full_scale_flag), .overrange_flag(overrange_flag));
	gain_ctrl_model gain_ctrl_model_inst (
		.clk(clk), .reset(reset), .near_full_scale_flag(near_full_scale_flag),
		.atten_on(atten_on), .inserts(inserts));

	// free-running sample clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic summarize();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one byte write; strobe drops for an edge so back-to-back calls never collide
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		#1;
		`CHK("reg_rdata", e, reg_rdata)
	endtask

	// one-sample excursion: the flag lands seven edges after the sample is launched, six after capture
	task automatic hit(input fast_detect_pkg::sample_t s, input logic e);
		@(posedge clk);
		sample <= s;
		@(posedge clk);
		sample <= 14'h0000;
		tick(5);
		#1;
		`CHK("flag early", 1'b0, near_full_scale_flag)
		tick(1);
		#1;
		`CHK("flag lat", e, near_full_scale_flag)
	endtask

	// hang guard: the whole sequence needs well under this many cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			summarize();
		end
	end

	initial begin
		{reset, sample, overrange_in, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		reset = 1'b1;
		num_errors = 0;
		checks = 0;
		cycles = 0;
		tick(2);
		reset <= 1'b0;
		for (int i = 0; i < 7; i++)
			rd(regs_a[i], rst_v[i]);
		for (int i = 0; i < 7; i++)
			wr(regs_a[i], new_v[i]);
		for (int i = 0; i < 7; i++)
			rd(regs_a[i], new_v[i]);
		wr(8'h46, 8'h5A);
		rd(8'h46, 8'h00);
		tick(40);
		hit(14'h3000, 1'b1);
		// a mid-level sample above the lower threshold restarts the dwell and delays release
		tick(3);
		sample <= 14'h0BB8;
		tick(1);
		sample <= 14'h0000;
		tick(50);
		#1;
		`CHK("flag held", 1'b1, near_full_scale_flag)
		`CHK("atten held", 1'b1, atten_on)
		tick(40);
		#1;
		`CHK("flag released", 1'b0, near_full_scale_flag)
		`CHK("atten released", 1'b0, atten_on)
		`CHK("inserts", 1, inserts)
		hit(14'h1000, 1'b1);
		tick(80);
		hit(14'h0FFF, 1'b0);
		hit(14'h2000, 1'b1);
		tick(80);
		wr(`FD_ADDR_CONTROL, 8'h00);
		hit(14'h3000, 1'b0);
		// overrange is not gated by the enable and lasts one cycle per input cycle
		@(posedge clk);
		overrange_in <= 1'b1;
		@(posedge clk);
		overrange_in <= 1'b0;
		tick(34);
		#1;
		`CHK("ovr early", 1'b0, overrange_flag)
		tick(1);
		#1;
		`CHK("ovr at 36", 1'b1, overrange_flag)
		tick(1);
		#1;
		`CHK("ovr after", 1'b0, overrange_flag)
		summarize();
	end
endmodule
`default_nettype wire

// >>> src/delay_line.sv
// fixed-length shift register used to align pipeline taps
`timescale 1ns/1ps
`default_nettype none
module delay_line #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 1
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage_q [DEPTH];

	// each stage is a plain flop; reset clears the line so no stale flag escapes
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage_q[i] <= '0;
			end
		end else begin
			stage_q[0] <= din;
			for (int i = 1; i < DEPTH; i++) begin
				stage_q[i] <= stage_q[i-1];
			end
		end
	end

	assign dout = stage_q[DEPTH-1];
endmodule
`default_nettype wire

// >>> src/fast_detect_defs.svh
// register offsets, field positions and latencies for the fast threshold detector
`ifndef FAST_DETECT_DEFS_SVH
`define FAST_DETECT_DEFS_SVH

`define FD_ADDR_CONTROL     8'h45
`define FD_ADDR_UPPER_LO    8'h47
`define FD_ADDR_UPPER_HI    8'h48
`define FD_ADDR_LOWER_LO    8'h49
`define FD_ADDR_LOWER_HI    8'h4A
`define FD_ADDR_DWELL_LO    8'h4B
`define FD_ADDR_DWELL_HI    8'h4C
`define FD_ENABLE_BIT       0
`define FD_REG_RESET        8'h00
`define FD_DWELL_RESET      16'h0001
`define FD_UPPER_LATENCY    7
`define FD_OVR_LATENCY      36
`define FD_FULL_SCALE_EXP   13
`define FD_DELAY_DEPTH      36
`define FD_HOLDOFF_COUNT    5'h1C // clocks by which the release path trails the fast path, less one

`endif

// >>> src/fast_detect_pkg.sv
// types shared by the fast threshold detector
package fast_detect_pkg;
	typedef logic [13:0] sample_t;
	typedef logic [15:0] magnitude_t;
	typedef enum logic [0:0] {
		IND_IDLE = 1'b0,
		IND_HELD = 1'b1
	} indicator_state_t;
endpackage

// >>> src/fast_threshold_detect.sv
// fast threshold detector with dwell-based release and overrange flag
`timescale 1ns/1ps
`default_nettype none
`include "fast_detect_defs.svh"

// Behaviour
// - detection runs only while bit 0 of the control register at 0x45 is set.
// - the indicator asserts when sample magnitude exceeds the upper threshold at 0x47/0x48.
// - the indicator stays low while magnitude is below threshold and nothing has triggered it.
// - comparisons use sample magnitude only, so equal positive and negative excursions match.
// - an upper exceedance shows on the indicator seven clocks after its sample arrives.
// - once set, the indicator holds until magnitude stays below the lower threshold for the dwell count.
// - the lower threshold is a 16-bit value from 0x49/0x4A compared with the sample magnitude.
// - the lower comparison uses the full pipeline path and carries the full pipeline latency.
// - the dwell count is programmable from 1 to 65535 clocks via 0x4B/0x4C.
// - threshold values are scaled so that two to the thirteenth equals full-scale magnitude.
// - the overrange flag appears 36 clocks after the overrange at the input.
module fast_threshold_detect (
	input  wire logic                     clk,
	input  wire logic                     reset,
	input  wire fast_detect_pkg::sample_t sample,
	input  wire logic                     overrange_in,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	input  wire logic [7:0]               reg_addr,
	input  wire logic [7:0]               reg_wdata,
	output logic      [7:0]               reg_rdata,
	output logic                          near_full_scale_flag,
	output logic                          overrange_flag
);
	localparam int UP_STAGES = `FD_UPPER_LATENCY - 3;
	localparam int LO_STAGES = `FD_OVR_LATENCY - 3;

	logic [7:0]                        control_q;
	logic [15:0]                       upper_thr_q;
	logic [15:0]                       lower_thr_q;
	logic [15:0]                       dwell_q;
	logic [7:0]                        reg_rdata_q;
	fast_detect_pkg::magnitude_t       mag_q;
	logic                              above_upper_q;
	logic                              below_lower_q;
	logic                              upper_hit;
	logic                              lower_ok;
	logic                              ovr_d;
	logic [15:0]                       dwell_cnt_q;
	logic [4:0]                        holdoff_q;
	fast_detect_pkg::indicator_state_t state_q;
	logic                              flag_q;
	logic                              ovr_q;
	logic                              enable;

	// magnitude of a 14-bit two's complement sample; full scale is 2^13
	function automatic fast_detect_pkg::magnitude_t magnitude(input fast_detect_pkg::sample_t s);
		logic [13:0] neg;
		neg = 14'(~s + 14'h0001);
		if (s[13]) begin
			magnitude = {2'h0, neg};
		end else begin
			magnitude = {2'h0, s};
		end
	endfunction

	// byte merge for the split registers
	function automatic logic [15:0] set_byte(input logic [15:0] cur, input logic hi, input logic [7:0] b);
		if (hi) begin
			set_byte = {b, cur[7:0]};
		end else begin
			set_byte = {cur[15:8], b};
		end
	endfunction

	assign enable = control_q[`FD_ENABLE_BIT];

	// register writes; a dwell of zero releases like a dwell of one since the legal range starts there
	always_ff @(posedge clk) begin
		if (reset) begin
			control_q   <= `FD_REG_RESET;
			upper_thr_q <= 16'h0000;
			lower_thr_q <= 16'h0000;
			dwell_q     <= `FD_DWELL_RESET;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`FD_ADDR_CONTROL:  control_q   <= reg_wdata;
				`FD_ADDR_UPPER_LO: upper_thr_q <= set_byte(upper_thr_q, 1'b0, reg_wdata);
				`FD_ADDR_UPPER_HI: upper_thr_q <= set_byte(upper_thr_q, 1'b1, reg_wdata);
				`FD_ADDR_LOWER_LO: lower_thr_q <= set_byte(lower_thr_q, 1'b0, reg_wdata);
				`FD_ADDR_LOWER_HI: lower_thr_q <= set_byte(lower_thr_q, 1'b1, reg_wdata);
				`FD_ADDR_DWELL_LO: dwell_q     <= set_byte(dwell_q, 1'b0, reg_wdata);
				`FD_ADDR_DWELL_HI: dwell_q     <= set_byte(dwell_q, 1'b1, reg_wdata);
				default: ;
			endcase
		end
	end

	// read data is registered; unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`FD_ADDR_CONTROL:  reg_rdata_q <= control_q;
				`FD_ADDR_UPPER_LO: reg_rdata_q <= upper_thr_q[7:0];
				`FD_ADDR_UPPER_HI: reg_rdata_q <= upper_thr_q[15:8];
				`FD_ADDR_LOWER_LO: reg_rdata_q <= lower_thr_q[7:0];
				`FD_ADDR_LOWER_HI: reg_rdata_q <= lower_thr_q[15:8];
				`FD_ADDR_DWELL_LO: reg_rdata_q <= dwell_q[7:0];
				`FD_ADDR_DWELL_HI: reg_rdata_q <= dwell_q[15:8];
				default:           reg_rdata_q <= 8'h00;
			endcase
		end
	end
	assign reg_rdata = reg_rdata_q;

	// stage 1: magnitude; stage 2: both comparisons
	always_ff @(posedge clk) begin
		if (reset) begin
			mag_q         <= 16'h0000;
			above_upper_q <= 1'b0;
			below_lower_q <= 1'b0;
		end else begin
			mag_q         <= magnitude(sample);
			above_upper_q <= mag_q > upper_thr_q;
			below_lower_q <= mag_q < lower_thr_q;
		end
	end

	// fast path padded so the flag lands seven clocks after its sample
	delay_line #(
		.WIDTH (1),
		.DEPTH (UP_STAGES)
	) u_upper_delay (
		.clk   (clk),
		.reset (reset),
		.din   (above_upper_q),
		.dout  (upper_hit)
	);

	// release path carries the full pipeline delay, trading speed for resolution
	delay_line #(
		.WIDTH (1),
		.DEPTH (LO_STAGES)
	) u_lower_delay (
		.clk   (clk),
		.reset (reset),
		.din   (below_lower_q),
		.dout  (lower_ok)
	);

	// overrange travels beside the pipeline output
	delay_line #(
		.WIDTH (1),
		.DEPTH (`FD_OVR_LATENCY - 1)
	) u_ovr_delay (
		.clk   (clk),
		.reset (reset),
		.din   (overrange_in),
		.dout  (ovr_d)
	);

	// indicator state and dwell counter
	always_ff @(posedge clk) begin
		if (reset || !enable) begin
			state_q     <= fast_detect_pkg::IND_IDLE;
			dwell_cnt_q <= 16'h0000;
			flag_q      <= 1'b0;
		end else begin
			unique case (state_q)
				fast_detect_pkg::IND_IDLE: begin
					dwell_cnt_q <= 16'h0000;
					if (upper_hit) begin
						state_q <= fast_detect_pkg::IND_HELD;
						flag_q  <= 1'b1;
					end else begin
						flag_q <= 1'b0;
					end
				end
				fast_detect_pkg::IND_HELD: begin
					if (upper_hit || !lower_ok || holdoff_q != 5'h00) begin
						dwell_cnt_q <= 16'h0000;
					end else if (16'(dwell_cnt_q + 16'h0001) >= dwell_q) begin
						state_q     <= fast_detect_pkg::IND_IDLE;
						flag_q      <= 1'b0;
						dwell_cnt_q <= 16'h0000;
					end else begin
						dwell_cnt_q <= 16'(dwell_cnt_q + 16'h0001);
					end
				end
			endcase
		end
	end
	// release path lags the fast path; without this wait the dwell would count samples older than the hit
	always_ff @(posedge clk) begin
		if (reset || !enable) begin
			holdoff_q <= 5'h00;
		end else if (upper_hit) begin
			holdoff_q <= `FD_HOLDOFF_COUNT;
		end else if (holdoff_q != 5'h00) begin
			holdoff_q <= 5'(holdoff_q - 5'h01);
		end
	end

	// overrange is always live, independent of the detect enable
	always_ff @(posedge clk) begin
		if (reset) begin
			ovr_q <= 1'b0;
		end else begin
			ovr_q <= ovr_d;
		end
	end

	assign near_full_scale_flag = flag_q;
	assign overrange_flag       = ovr_q;

	// helper: magnitude above upper threshold, taken from the raw sample input one clock ahead of the comparator
	logic exceed_now;
	assign exceed_now = magnitude(sample) > upper_thr_q;

	sequence s_exceed;
		enable && exceed_now && !reset;
	endsequence

	sequence s_enable_run;
		enable [*7];
	endsequence

	property p_upper_latency;
		@(posedge clk) disable iff (reset)
		s_exceed ##1 s_enable_run |-> near_full_scale_flag;
	endproperty
	a_upper_latency: assert property (p_upper_latency) else $error("flag missing seven clocks after exceedance");

	property p_enable_gate;
		@(posedge clk) disable iff (reset)
		!enable |=> !near_full_scale_flag;
	endproperty
	a_enable_gate: assert property (p_enable_gate) else $error("flag high with detection disabled");

	property p_ovr_latency;
		@(posedge clk) disable iff (reset)
		overrange_in |-> ##36 overrange_flag;
	endproperty
	a_ovr_latency: assert property (p_ovr_latency) else $error("overrange not reported after 36 clocks");

	property p_ovr_no_false;
		@(posedge clk) disable iff (reset)
		!overrange_in |-> ##36 !overrange_flag;
	endproperty
	a_ovr_no_false: assert property (p_ovr_no_false) else $error("overrange reported without cause");

	property p_rise_cause;
		@(posedge clk) disable iff (reset)
		$rose(near_full_scale_flag) |-> $past(upper_hit);
	endproperty
	a_rise_cause: assert property (p_rise_cause) else $error("flag rose without an upper hit");

	property p_hold_while_high;
		@(posedge clk) disable iff (reset)
		(near_full_scale_flag && enable && !lower_ok) |=> near_full_scale_flag;
	endproperty
	a_hold_while_high: assert property (p_hold_while_high) else $error("flag dropped while above lower threshold");

	property p_restart_dwell;
		@(posedge clk) disable iff (reset)
		(state_q == fast_detect_pkg::IND_HELD && enable && !lower_ok) |=> dwell_cnt_q == 16'h0000;
	endproperty
	a_restart_dwell: assert property (p_restart_dwell) else $error("dwell counter not restarted");

	property p_fall_cause;
		@(posedge clk) disable iff (reset)
		($fell(near_full_scale_flag) && $past(enable) && !$past(reset)) |-> $past(lower_ok) && !$past(upper_hit);
	endproperty
	a_fall_cause: assert property (p_fall_cause) else $error("flag cleared without release condition");

	property p_sign_blind;
		@(posedge clk) disable iff (reset)
		magnitude(sample) == magnitude(14'(~sample + 14'h0001)) && mag_q <= 16'h2000;
	endproperty
	a_sign_blind: assert property (p_sign_blind) else $error("magnitude depends on sign");

	property p_dwell_bound;
		@(posedge clk) disable iff (reset)
		state_q == fast_detect_pkg::IND_HELD |-> dwell_cnt_q < dwell_q || dwell_q == 16'h0000;
	endproperty
	a_dwell_bound: assert property (p_dwell_bound) else $error("dwell counter beyond programmed count");

	property p_release_wait;
		@(posedge clk) disable iff (reset)
		(near_full_scale_flag && enable && holdoff_q != 5'h00) |=> near_full_scale_flag;
	endproperty
	a_release_wait: assert property (p_release_wait) else $error("flag released before the lower path caught up");

	property p_lower_pair;
		@(posedge clk) disable iff (reset)
		(reg_wr && reg_addr == `FD_ADDR_LOWER_HI) |=> lower_thr_q == {$past(reg_wdata), $past(lower_thr_q[7:0])};
	endproperty
	a_lower_pair: assert property (p_lower_pair) else $error("lower threshold high byte misplaced");
endmodule
`default_nettype wire
